// ===== design/tsec_map.svh
// Purpose: Register indices, event numbers, reset values and field layout for the
//          two-stage event controller.
// Assumes: Word-indexed register port, one register per index.
// Notes:   Definitions only; included by the top, the checker and the testbench.
`ifndef TSEC_MAP_SVH
`define TSEC_MAP_SVH

// Register indices on the core register port
`define TSEC_IDX_LATCH      4'h0
`define TSEC_IDX_MASK       4'h1
`define TSEC_IDX_PEND       4'h2
`define TSEC_IDX_PMASK_LO   4'h3
`define TSEC_IDX_PMASK_HI   4'h4
`define TSEC_IDX_PSTAT_LO   4'h5
`define TSEC_IDX_PSTAT_HI   4'h6
`define TSEC_IDX_PWAKE_LO   4'h7
`define TSEC_IDX_PWAKE_HI   4'h8
`define TSEC_IDX_ASSIGN0    4'h9
`define TSEC_IDX_ASSIGN3    4'hc

// Event priority numbers
`define TSEC_EVT_EMU        5'h00
`define TSEC_EVT_RST        5'h01
`define TSEC_EVT_NMI        5'h02
`define TSEC_EVT_EXC        5'h03
`define TSEC_EVT_RSVD       5'h04
`define TSEC_EVT_HWERR      5'h05
`define TSEC_EVT_TMR        5'h06
`define TSEC_EVT_GP_FIRST   5'h07
`define TSEC_EVT_NONE       5'h10

// Reset values
`define TSEC_MASK_RST       16'h000f
`define TSEC_MASK_FIXED     16'h000f
`define TSEC_PMASK_RST      32'h0000_0000
`define TSEC_PWAKE_RST      32'h0000_0000
`define TSEC_ASSIGN0_RST    32'h0000_0000
`define TSEC_ASSIGN1_RST    32'h3332_2221
`define TSEC_ASSIGN2_RST    32'h5544_4443
`define TSEC_ASSIGN3_RST    32'h6660_0005

// Field layout of the level assignment words
`define TSEC_ASSIGN_W       4
`define TSEC_SRC_PER_WORD   8

`endif

// ===== design/tsec_pkg.sv
// Purpose: Shared types of the two-stage event controller.
// Assumes: tsec_map.svh holds all numbers.
// Notes:   Register port request travels as one packed struct.
`default_nettype none
package tsec_pkg;
    // Core register port request
    typedef struct packed {
        logic        sel;     // Access this cycle
        logic        wr;      // 1 write, 0 read
        logic [3:0]  idx;     // Register index
        logic [31:0] wdata;   // Write data
        logic        sup;     // Supervisor mode of the access
    } tsec_mmr_req_t;

    // Register port answer
    typedef struct packed {
        logic        ack;     // Access done
        logic        err;     // Refused: user mode or unmapped
        logic [31:0] rdata;   // Read data
    } tsec_mmr_rsp_t;
endpackage
`default_nettype wire

// ===== design/tsec_top.sv
// Purpose: Two-stage event controller: peripheral routing stage feeding
//          the core event stage with latch, mask and pending registers.
// Assumes: Peripheral, pipeline and register inputs are on i_clk_sys;
//          only the external nonmaskable pin is asynchronous.
// Notes:   All state freezes while i_ce is low.
`default_nettype none
`include "tsec_map.svh"

module tsec_top #(
    parameter int N_SRC = 32        // Peripheral sources
) (
    input  wire logic                  i_clk_sys,    // Core clock
    input  wire logic                  i_rst_b,      // Async reset, low
    input  wire logic                  i_ce,         // Clock enable
    input  wire logic [N_SRC-1:0]      i_periph_irq, // Peripheral requests
    input  wire logic                  i_emu_req,    // Emulation request
    input  wire logic                  i_rst_req,    // Core reset request
    input  wire logic                  i_nmi_pin,    // External NMI, async
    input  wire logic                  i_wdog_nmi,   // Watchdog NMI
    input  wire logic                  i_exc_req,    // Pipeline exception
    input  wire logic                  i_hwerr_req,  // Hardware error
    input  wire logic                  i_tmr_req,    // Core timer
    input  wire logic [8:0]            i_swi_req,    // Software raise 7..15
    input  wire logic                  i_gie_set,    // Global enable instr
    input  wire logic                  i_gie_clr,    // Global disable instr
    input  wire logic                  i_core_ready, // Pipeline can accept
    input  wire logic                  i_evt_return, // Return from event
    input  wire logic [31:0]           i_ret_pc,     // Return address
    input  wire logic                  i_core_idle,  // Core idle or asleep
    input  wire tsec_pkg::tsec_mmr_req_t i_mmr,      // Register request
    output tsec_pkg::tsec_mmr_rsp_t    o_mmr,        // Register answer
    output logic [15:0]                o_pending,    // Pending register
    output logic                       o_evt_take,   // Event accepted
    output logic [4:0]                 o_evt_num,    // Accepted event
    output logic [31:0]                o_ret_addr,   // Active return addr
    output logic                       o_wakeup,     // Wake the core
    output logic                       o_core_reset, // Reset the core
    output logic                       o_emu_mode,   // Emulation mode
    output logic                       o_gie         // Global enable state
);
    import tsec_pkg::*;

    // Lowest set bit of a 16-bit vector, TSEC_EVT_NONE when empty
    function automatic logic [4:0] lowest(input logic [15:0] v);
        logic [4:0] r;
        r = `TSEC_EVT_NONE;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // One-hot of an event number; none gives zero
    function automatic logic [15:0] onehot(input logic [4:0] n);
        logic [15:0] r;
        r = 16'h0000;
        if (!n[4]) begin
            r[n[3:0]] = 1'b1;
        end
        return r;
    endfunction

    // Registers
    logic [15:0]         latch_r;
    logic [15:0]         latch_nxt;
    logic [15:0]         mask_r;
    logic [15:0]         pend_r;
    logic [15:0]         pend_nxt;
    logic [31:0]         pmask_r;
    logic [31:0]         pwake_r;
    logic [31:0]         pstat_r;
    logic [31:0]         assign_r [4];
    logic [31:0]         ret_r [16];
    logic                gie_r;
    logic [8:0]          lvl_d1_r;
    logic [8:0]          lvl_d2_r;
    logic                nmi_s1_r;
    logic                nmi_s2_r;
    tsec_mmr_rsp_t       mmr_r;
    logic                take_r;
    logic [4:0]          num_r;
    logic [31:0]         ret_out_r;
    logic                wake_r;
    logic                creset_r;
    logic                emu_r;

    // Routing stage: mask each source, OR onto its assigned level
    logic [31:0]         src_vec;
    logic [31:0]         src_on;
    logic [8:0]          gp_level;

    assign src_vec = 32'(i_periph_irq);
    assign src_on  = src_vec & pmask_r;

    always_comb begin
        logic [3:0] lvl;
        lvl      = 4'h0;
        gp_level = 9'h000;
        for (int s = 0; s < 32; s++) begin
            lvl = assign_r[s / `TSEC_SRC_PER_WORD]
                    [(s % `TSEC_SRC_PER_WORD) * `TSEC_ASSIGN_W +: 4];
            if (src_on[s] && lvl < 4'h9) begin
                gp_level[lvl] = 1'b1;
            end
        end
    end

    logic [8:0]          gp_rise;
    assign gp_rise = lvl_d1_r & ~lvl_d2_r;

    // nonmaskable from watchdog or synchronised pin
    logic                nmi_any;
    assign nmi_any = nmi_s2_r | i_wdog_nmi;

    // event set vector; bit 4 reserved never sets
    // exception from pipeline, interrupts from sources
    logic [15:0]         set_vec;
    assign set_vec = {gp_rise | i_swi_req, i_tmr_req, i_hwerr_req, 1'b0,
                      i_exc_req, nmi_any, i_rst_req, i_emu_req};

    // mask gates servicing; global enable on levels 7..15
    logic [15:0]         enable_vec;
    assign enable_vec = (mask_r | `TSEC_MASK_FIXED)
                      & {{9{gie_r}}, 7'h7f};

    logic [4:0]          sel_num;
    logic [4:0]          top_num;
    logic                take;
    logic [15:0]         take_oh;
    logic [15:0]         ret_oh;
    assign sel_num = lowest(latch_r & enable_vec);
    assign top_num = lowest(pend_r);
    assign take    = i_core_ready && sel_num != `TSEC_EVT_NONE
                     && sel_num < top_num;
    assign take_oh = take ? onehot(sel_num) : 16'h0000;
    assign ret_oh  = i_evt_return ? onehot(top_num) : 16'h0000;

    // Register port decode; mask and all maps need supervisor mode
    logic                acc;
    logic                wr_ok;
    logic                mapped;
    logic                wr_latch;
    logic                wr_mask;
    logic                wr_pmask;
    logic                wr_pwake;
    logic                wr_assign;
    logic [1:0]          assign_sel;
    logic [31:0]         rd_val;
    assign acc        = i_mmr.sel && i_mmr.sup;
    assign mapped     = i_mmr.idx <= `TSEC_IDX_ASSIGN3;
    assign wr_ok      = acc && i_mmr.wr && mapped;
    assign wr_latch   = wr_ok && i_mmr.idx == `TSEC_IDX_LATCH;
    assign wr_mask    = wr_ok && i_mmr.idx == `TSEC_IDX_MASK;
    assign wr_pmask   = wr_ok && i_mmr.idx == `TSEC_IDX_PMASK_LO;
    assign wr_pwake   = wr_ok && i_mmr.idx == `TSEC_IDX_PWAKE_LO;
    assign wr_assign  = wr_ok && i_mmr.idx >= `TSEC_IDX_ASSIGN0;
    assign assign_sel = 2'(i_mmr.idx - `TSEC_IDX_ASSIGN0);

    // Read mux; high halves of the pairs have no sources and read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (i_mmr.idx == `TSEC_IDX_LATCH) begin
            rd_val = 32'(latch_r);
        end else if (i_mmr.idx == `TSEC_IDX_MASK) begin
            rd_val = 32'(mask_r | `TSEC_MASK_FIXED);
        end else if (i_mmr.idx == `TSEC_IDX_PEND) begin
            rd_val = 32'(pend_r);
        end else if (i_mmr.idx == `TSEC_IDX_PMASK_LO) begin
            rd_val = pmask_r;
        end else if (i_mmr.idx == `TSEC_IDX_PSTAT_LO) begin
            rd_val = pstat_r;
        end else if (i_mmr.idx == `TSEC_IDX_PWAKE_LO) begin
            rd_val = pwake_r;
        end else if (i_mmr.idx >= `TSEC_IDX_ASSIGN0 && mapped) begin
            rd_val = assign_r[assign_sel];
        end
    end

    // software write only on masked bits; set beats clear
    // accept clears latch, next edge queues again
    always_comb begin
        latch_nxt = latch_r & ~take_oh;
        if (wr_latch) begin
            latch_nxt = (latch_nxt & enable_vec)
                      | (i_mmr.wdata[15:0] & ~enable_vec);
        end
        latch_nxt = latch_nxt | set_vec;
    end

    // pending tracks every active or nested event
    // pending sets on accept and clears on return of its top bit
    assign pend_nxt = (pend_r & ~ret_oh) | take_oh;

    // level sampling and NMI pin synchroniser
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lvl_d1_r <= 9'h000;
            lvl_d2_r <= 9'h000;
            nmi_s1_r <= 1'b0;
            nmi_s2_r <= 1'b0;
        end else if (i_ce) begin
            lvl_d1_r <= gp_level;
            lvl_d2_r <= lvl_d1_r;
            nmi_s1_r <= i_nmi_pin;
            nmi_s2_r <= nmi_s1_r;
        end
    end

    // core event latch and pending registers
    // edge, sample, latch, pending: three cycles at best
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            latch_r <= 16'h0000;
            pend_r  <= 16'h0000;
        end else if (i_ce) begin
            latch_r <= latch_nxt;
            pend_r  <= pend_nxt;
        end
    end

    // supervisor mask writes and global enable instructions
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mask_r <= `TSEC_MASK_RST;
            gie_r  <= 1'b0;
        end else if (i_ce) begin
            if (wr_mask) begin
                mask_r <= i_mmr.wdata[15:0] | `TSEC_MASK_FIXED;
            end
            if (i_gie_set) begin
                gie_r <= 1'b1;
            end else if (i_gie_clr) begin
                gie_r <= 1'b0;
            end
        end
    end

    // peripheral mask, status and wakeup registers
    // status follows the raw request level
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pmask_r <= `TSEC_PMASK_RST;
            pwake_r <= `TSEC_PWAKE_RST;
            pstat_r <= 32'h0000_0000;
        end else if (i_ce) begin
            pstat_r <= src_vec;
            if (wr_pmask) begin
                pmask_r <= i_mmr.wdata;
            end
            if (wr_pwake) begin
                pwake_r <= i_mmr.wdata;
            end
        end
    end

    // level assignment words, default routing after reset
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            assign_r[0] <= `TSEC_ASSIGN0_RST;
            assign_r[1] <= `TSEC_ASSIGN1_RST;
            assign_r[2] <= `TSEC_ASSIGN2_RST;
            assign_r[3] <= `TSEC_ASSIGN3_RST;
        end else if (i_ce && wr_assign) begin
            assign_r[assign_sel] <= i_mmr.wdata;
        end
    end

    // one return address slot per event; no reset needed for data
    always_ff @(posedge i_clk_sys) begin
        if (i_ce && take) begin
            ret_r[sel_num[3:0]] <= i_ret_pc;
        end
    end

    // Register port answer, one cycle after the request
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mmr_r <= '0;
        end else if (i_ce) begin
            mmr_r.ack   <= i_mmr.sel;
            mmr_r.err   <= i_mmr.sel && !(i_mmr.sup && mapped);
            mmr_r.rdata <= acc && !i_mmr.wr ? rd_val : 32'h0000_0000;
        end
    end

    // emulation mode and core reset from accepted events
    // wake only for sources set in the wakeup register while the core sleeps
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            take_r    <= 1'b0;
            num_r     <= `TSEC_EVT_NONE;
            ret_out_r <= 32'h0000_0000;
            wake_r    <= 1'b0;
            creset_r  <= 1'b0;
            emu_r     <= 1'b0;
        end else if (i_ce) begin
            take_r    <= take;
            num_r     <= take ? sel_num : `TSEC_EVT_NONE;
            ret_out_r <= top_num[4] ? 32'h0000_0000 : ret_r[top_num[3:0]];
            wake_r    <= i_core_idle && |(src_vec & pwake_r);
            creset_r  <= take && sel_num == `TSEC_EVT_RST;
            if (take && sel_num == `TSEC_EVT_EMU) begin
                emu_r <= 1'b1;
            end else if (ret_oh[0]) begin
                emu_r <= 1'b0;
            end
        end
    end

    // Outputs straight from flip-flops
    assign o_mmr        = mmr_r;
    assign o_pending    = pend_r;
    assign o_evt_take   = take_r;
    assign o_evt_num    = num_r;
    assign o_ret_addr   = ret_out_r;
    assign o_wakeup     = wake_r;
    assign o_core_reset = creset_r;
    assign o_emu_mode   = emu_r;
    assign o_gie        = gie_r;
endmodule
`default_nettype wire

// ===== test/tsec_checker.sv
// Purpose: Port-level assertions for the two-stage event controller.
// Assumes: One clock domain; bound to every tsec_top instance.
// Notes:   Looks only at the ports of the design.
`default_nettype none
`include "tsec_map.svh"
module tsec_checker #(
    parameter int N_SRC = 32                        // Peripheral sources
) (
    input wire logic                    i_clk_sys,    // Core clock
    input wire logic                    i_rst_b,      // Async reset, low
    input wire logic                    i_ce,         // Clock enable
    input wire logic [N_SRC-1:0]        i_periph_irq, // Requests
    input wire logic                    i_core_idle,  // Core idle
    input wire logic                    i_evt_return, // Return pulse
    input wire tsec_pkg::tsec_mmr_req_t i_mmr,        // Register request
    input wire tsec_pkg::tsec_mmr_rsp_t o_mmr,        // Register answer
    input wire logic [15:0]             o_pending,    // Pending
    input wire logic                    o_evt_take,   // Accept pulse
    input wire logic [4:0]              o_evt_num,    // Accepted number
    input wire logic                    o_wakeup,     // Wake request
    input wire logic                    o_core_reset, // Core reset
    input wire logic                    o_emu_mode    // Emulation mode
);
    import tsec_pkg::*;
    // Bits of higher priority than the accepted event
    wire logic [15:0] above_w = (16'h0001 << o_evt_num[3:0]) - 16'h0001;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    // Register port steps
    sequence s_req;
        i_ce && i_mmr.sel;
    endsequence
    sequence s_refused;
        s_req ##0 (!i_mmr.sup || i_mmr.idx > `TSEC_IDX_ASSIGN3);
    endsequence
    property p_ack;
        s_req |=> o_mmr.ack;
    endproperty
    property p_no_ack;
        i_ce && !i_mmr.sel |=> !o_mmr.ack;
    endproperty
    property p_refuse;
        s_refused |=> o_mmr.err && o_mmr.rdata == 32'h0;
    endproperty
    // Event acceptance
    property p_idle_num;
        !o_evt_take |-> o_evt_num == `TSEC_EVT_NONE;
    endproperty
    property p_take_pend;
        o_evt_take |-> o_pending[o_evt_num[3:0]];
    endproperty
    // A bit already active above it forbids the accept
    property p_nest_order;
        o_evt_take |-> (o_pending & $past(o_pending) & above_w) == 16'h0;
    endproperty
    property p_wake;
        i_ce && (!i_core_idle || i_periph_irq == '0) |=> !o_wakeup;
    endproperty
    property p_core_reset;
        o_evt_take && o_evt_num == `TSEC_EVT_RST |-> o_core_reset;
    endproperty
    property p_emu;
        o_evt_take && o_evt_num == `TSEC_EVT_EMU |-> o_emu_mode;
    endproperty
    // Pending bits drop only within two cycles after a return
    property p_pend_hold;
        !$past(i_evt_return) && !$past(i_evt_return, 2)
            |-> (o_pending | ~$past(o_pending)) == 16'hffff;
    endproperty

    a_ack: assert property (p_ack) else $error("no register ack");
    a_no_ack: assert property (p_no_ack) else $error("stray ack");
    a_refuse: assert property (p_refuse) else $error("not refused");
    a_idle_num: assert property (p_idle_num) else $error("bad num");
    a_take_pend: assert property (p_take_pend) else $error("no pend");
    a_nest_order: assert property (p_nest_order) else $error("order");
    a_wake: assert property (p_wake) else $error("stray wakeup");
    a_core_reset: assert property (p_core_reset) else $error("no rst");
    a_emu: assert property (p_emu) else $error("no emulation mode");
    a_pend_hold: assert property (p_pend_hold) else $error("drop");
endmodule

bind tsec_top tsec_checker #(.N_SRC(N_SRC)) u_tsec_checker (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_periph_irq(i_periph_irq), .i_core_idle(i_core_idle),
    .i_evt_return(i_evt_return), .i_mmr(i_mmr), .o_mmr(o_mmr),
    .o_pending(o_pending), .o_evt_take(o_evt_take), .o_evt_num(o_evt_num),
    .o_wakeup(o_wakeup), .o_core_reset(o_core_reset),
    .o_emu_mode(o_emu_mode)
);
`default_nettype wire

// ===== test/tsec_core_model.sv
// Purpose: Pipeline partner: accept readiness and event returns.
// Assumes: Changes its outputs at the falling edge.
// Notes:   Slow mode withholds ready every other cycle.
`default_nettype none
module tsec_core_model (
    input  wire logic        i_clk_sys, // Core clock
    input  wire logic        i_rst_b,   // Async reset, low
    input  wire logic        i_slow,    // Stall every other cycle
    input  wire logic        i_hold,    // Keep handlers running
    input  wire logic [15:0] i_pending, // Pending register
    output var  logic        o_ready,   // Pipeline can accept
    output var  logic        o_return   // Return from event
);
    logic [2:0] run_r;
    // one return per event
    // Handler lasts six cycles so pending settles before the next return
    always_ff @(negedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ready  <= 1'b0;
            o_return <= 1'b0;
            run_r    <= 3'h0;
        end else begin
            o_ready  <= i_slow ? !o_ready : 1'b1;
            o_return <= run_r == 3'h5;
            if (run_r == 3'h5 || i_hold || i_pending == 16'h0) begin
                run_r <= 3'h0;
            end else begin
                run_r <= run_r + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Purpose: Self-checking bench for the two-stage event controller.
// Assumes: Inputs change at the falling edge; fixed xorshift seed.
// Notes:   Clock enable drops once near the end to exercise the freeze.
`default_nettype none
`include "tsec_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import tsec_pkg::*;
    localparam int LIMIT = 20000;
    localparam logic [3:0] RIX [8] = '{`TSEC_IDX_MASK, `TSEC_IDX_PEND,
        `TSEC_IDX_PMASK_LO, `TSEC_IDX_PWAKE_LO, 4'h9, 4'ha, 4'hb, 4'hc};
    localparam logic [31:0] RVAL [8] = '{`TSEC_MASK_RST, 0, 0, 0,
        `TSEC_ASSIGN0_RST, `TSEC_ASSIGN1_RST, `TSEC_ASSIGN2_RST,
        `TSEC_ASSIGN3_RST};
    localparam logic [4:0] EVN [7] = '{0, 1, 2, 2, 3, 5, 6};
    logic          clk = 0, rst_b = 0, gset = 0, gclr = 0, ce = 1;
    logic          idle = 0, slow = 0, hold = 0;
    logic [31:0]   irq = 0, ret_pc = 0, x, pc, seed = 25;
    logic [6:0]    ev = 0;
    logic [8:0]    swi = 0;
    logic [4:0]    n, num;
    logic [15:0]   pend;
    logic [31:0]   ret_addr;
    logic          take, wake, gie, cres, emum;
    wire logic     ready, ret;
    tsec_mmr_req_t req = '0;
    tsec_mmr_rsp_t rsp, r;
    int            err_total = 0, n_checks = 0, cyc = 0, s, lat;

    tsec_top #(.N_SRC(32)) dut (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce),
        .i_periph_irq(irq), .i_emu_req(ev[0]), .i_rst_req(ev[1]),
        .i_nmi_pin(ev[2]), .i_wdog_nmi(ev[3]), .i_exc_req(ev[4]),
        .i_hwerr_req(ev[5]), .i_tmr_req(ev[6]), .i_swi_req(swi),
        .i_gie_set(gset), .i_gie_clr(gclr), .i_core_ready(ready),
        .i_evt_return(ret), .i_ret_pc(ret_pc), .i_core_idle(idle),
        .i_mmr(req), .o_mmr(rsp), .o_pending(pend), .o_evt_take(take),
        .o_evt_num(num), .o_ret_addr(ret_addr), .o_wakeup(wake),
        .o_core_reset(cres), .o_emu_mode(emum), .o_gie(gie)
    );
    tsec_core_model u_core (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_slow(slow), .i_hold(hold),
        .i_pending(pend), .o_ready(ready), .o_return(ret)
    );

    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            end_of_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Default routed level of a source
    function automatic int lvl(input int src);
        logic [127:0] t;
        t = {`TSEC_ASSIGN3_RST, `TSEC_ASSIGN2_RST,
             `TSEC_ASSIGN1_RST, `TSEC_ASSIGN0_RST};
        return 7 + int'(t[src*4 +: 4]);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // One register access; answer comes one cycle after it is taken
    task automatic acc(input logic w, input logic [3:0] ix,
                       input logic [31:0] d, input logic sp);
        @(negedge clk);
        req = '{sel: 1'b1, wr: w, idx: ix, wdata: d, sup: sp};
        @(negedge clk);
        req.sel = 1'b0;
        r = rsp;
    endtask
    task automatic pulse(input logic [8:0] sv, input logic [6:0] evv);
        @(negedge clk);
        swi = sv;
        ev = evv;
        @(negedge clk);
        swi = 9'h0;
        ev = 7'h0;
    endtask
    task automatic wtake(output logic [4:0] t);
        t = 5'h1f;
        for (int i = 0; i < 40 && t === 5'h1f; i++) begin
            @(negedge clk);
            if (take === 1'b1) t = num;
        end
    endtask
    task automatic wzero();
        for (int i = 0; i < 60 && pend !== 16'h0; i++) @(negedge clk);
    endtask
    task automatic end_of_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        for (int k = 0; k < 8; k++) begin
            acc(0, RIX[k], 0, 1);
            chk("reset value", RVAL[k], r.rdata);
        end
        acc(0, `TSEC_IDX_MASK, 0, 0);
        chk("user refused", 1, r.err);
        acc(0, 4'hd, 0, 1);
        chk("unmapped refused", 1, r.err);
        acc(1, `TSEC_IDX_PEND, 32'hffff, 1);
        acc(0, `TSEC_IDX_PEND, 0, 1);
        chk("pending read only", 0, r.rdata);
        acc(1, `TSEC_IDX_MASK, 32'hffef, 1);
        acc(0, `TSEC_IDX_MASK, 0, 1);
        chk("mask", 32'hffef, r.rdata);
        @(negedge clk) gset = 1'b1;
        @(negedge clk) gset = 1'b0;
        chk("global enable", 1, gie);
        // Dedicated events one by one
        for (int k = 0; k < 7; k++) begin
            pc = rnd();
            ret_pc = pc;
            pulse(9'h0, 7'h01 << k);
            wtake(n);
            chk("event number", EVN[k], n);
            chk("core reset", k == 1, cres);
            chk("emulation mode", k == 0, emum);
            @(negedge clk);
            chk("return address", pc, ret_addr);
            wzero();
        end
        // Random peripheral sources, masks, wake enables and stalls
        for (int it = 0; it < 16; it++) begin
            x = rnd();
            s = int'(x % 25);
            acc(1, `TSEC_IDX_PMASK_LO, {31'h0, x[8]} << s, 1);
            acc(1, `TSEC_IDX_PWAKE_LO, {31'h0, x[9]} << s, 1);
            @(negedge clk);
            idle = x[10];
            slow = x[11];
            irq[s] = 1'b1;
            lat = 0;
            while (lat < 20 && pend[lvl(s)] !== 1'b1) begin
                @(negedge clk);
                lat++;
            end
            chk("routed latency", x[8], lat >= 3 && lat < 20);
            acc(0, `TSEC_IDX_PSTAT_LO, 0, 1);
            chk("status", 32'h1 << s, r.rdata);
            chk("wakeup", x[9] & x[10], wake);
            irq[s] = 1'b0;
            wzero();
        end
        idle = 1'b0;
        slow = 1'b0;
        // Sources 9 and 10 share level 9; the second adds no new edge
        hold = 1'b1;
        acc(1, `TSEC_IDX_PMASK_LO, 32'h0000_0600, 1);
        irq[9] = 1'b1;
        wtake(n);
        chk("shared first", 9, n);
        irq[10] = 1'b1;
        repeat (4) @(negedge clk);
        acc(0, `TSEC_IDX_LATCH, 0, 1);
        chk("shared level", 0, r.rdata);
        irq = 32'h0;
        hold = 1'b0;
        wzero();
        // Nesting: software level 14, then timer and level 9 together
        hold = 1'b1;
        pulse(9'h080, 7'h00);
        wtake(n);
        chk("nest base", 14, n);
        pulse(9'h004, 7'h40);
        wtake(n);
        chk("nest timer", 6, n);
        acc(0, `TSEC_IDX_LATCH, 0, 1);
        chk("queued latch", 32'h0200, r.rdata);
        acc(0, `TSEC_IDX_PEND, 0, 1);
        chk("nested pending", 32'h4040, r.rdata);
        hold = 1'b0;
        wtake(n);
        chk("nest next", 9, n);
        wzero();
        // Masked level still latches; latch written while masked
        acc(1, `TSEC_IDX_MASK, 32'h7fef, 1);
        pulse(9'h100, 7'h00);
        repeat (6) @(negedge clk);
        acc(0, `TSEC_IDX_LATCH, 0, 1);
        chk("masked latch", 32'h8000, r.rdata);
        chk("masked pending", 0, pend);
        acc(1, `TSEC_IDX_LATCH, 0, 1);
        acc(0, `TSEC_IDX_LATCH, 0, 1);
        chk("latch write", 0, r.rdata);
        acc(1, `TSEC_IDX_MASK, 32'hffef, 1);
        // Global disable holds level 14 until enable
        @(negedge clk) gclr = 1'b1;
        @(negedge clk) gclr = 1'b0;
        pulse(9'h080, 7'h00);
        repeat (8) @(negedge clk);
        chk("global off", 0, pend);
        @(negedge clk) gset = 1'b1;
        @(negedge clk) gset = 1'b0;
        wtake(n);
        chk("global on", 14, n);
        wzero();
        // Freeze: a global disable is ignored while the enable is low
        @(negedge clk) ce = 1'b0;
        gclr = 1'b1;
        @(negedge clk) gclr = 1'b0;
        chk("frozen enable", 1, gie);
        ce = 1'b1;
        end_of_test();
    end
endmodule
`default_nettype wire
